/* File: design/addr_align.sv */
`timescale 1ns/1ns
// Forces even addresses for word, longword and fetch accesses
module addr_align (
	input  wire logic [15:0]   rawAddr,
	input  wire logic          wideAccess,
	input  wire logic          fetch,
	output logic      [15:0]   alignedAddr,
	output logic               oddSeen
);
	// Clear the low bit, and flag an odd wide or fetch address on oddSeen
	always_comb begin
		alignedAddr = rawAddr;
		if (wideAccess || fetch) begin
			alignedAddr[0] = 1'b0;
		end
		oddSeen = rawAddr[0] & (wideAccess | fetch);
	end
endmodule : addr_align

/* File: design/cpu_flags.sv */
`timescale 1ns/1ns
// Behaviour
// [RULE1] The flag register is eight bits wide, upper bits hold mask, user and half-carry.
// [RULE2] Bit 4 is a user bit that only the flag-register instructions read and write.
// [RULE3] Bit 3 takes the top bit of the result when updated.
// [RULE4] Bit 2 is one for a zero result and zero otherwise.
// [RULE5] Bit 1 is one on signed overflow of arithmetic and zero otherwise.
// [RULE6] Bit 0 is one on a carry out of an addition and zero otherwise.
// [RULE7] Bit 0 shows a borrow out of a subtraction.
// [RULE8] Bit 0 takes the bit shifted or rotated out.
// [RULE9] Bit instructions use bit 0 as a one-bit accumulator, source and destination.
// [RULE10] Operands may be bit, packed decimal, byte, word or longword.
// [RULE11] Bit instructions pick one bit 0 to 7 of a byte and touch only it.
// [RULE12] Decimal adjust treats a byte as two packed decimal digits.
// [RULE13] Software keeps word and longword operands at even addresses.
// [RULE14] An odd word or longword address raises no error and loses its low bit.
// [RULE15] Instruction fetch addresses are aligned the same way.
// [RULE16] Software should use only word or longword stack accesses.
// [RULE17] A flag keeps its value unless its instruction updates it.
module cpu_flags (
	input  wire logic                    ref_clk,
	input  wire logic                    reset,
	input  wire logic                    opValid,
	input  wire flags_pkg::op_t          opCode,
	input  wire flags_pkg::size_t        opSize,
	input  wire logic [31:0]             operandA,
	input  wire logic [31:0]             operandB,
	input  wire logic                    rotate,
	input  wire logic [2:0]              bitSel,
	input  wire logic                    bitInvert,
	input  wire flags_pkg::flagop_t      flagOp,
	input  wire logic [7:0]              flagImm,
	input  wire logic [15:0]             rawAddr,
	input  wire logic                    wideAccess,
	input  wire logic                    fetch,
	output logic      [31:0]             result,
	output logic      [7:0]              flagRegister,
	output logic      [15:0]             memAddr,
	output logic                         oddAddr
);
	logic [31:0] next_result;
	logic [7:0]  next_flags;
	logic        writeResult;
	logic [32:0] sum;
	logic [31:0] mask;
	logic [7:0]  bcdOut;
	logic        bcdCarry;
	logic        msb;
	logic        carry;
	logic        ovf;
	logic        half;
	logic        cIn;
	logic        bitVal;

	// Sign position of an operand size
	function automatic int unsigned topBit(input flags_pkg::size_t s);
		unique case (s)
			flags_pkg::SZ_WORD: topBit = 15;
			flags_pkg::SZ_LONG: topBit = 31;
			flags_pkg::SZ_BCD:  topBit = 7;
			flags_pkg::SZ_BIT:  topBit = 7;
			flags_pkg::SZ_BYTE: topBit = 7;
			default:            topBit = 7;
		endcase
	endfunction : topBit

	// Width mask of an operand size
	function automatic logic [31:0] sizeMask(input flags_pkg::size_t s);
		unique case (s)
			flags_pkg::SZ_WORD: sizeMask = 32'h0000ffff;
			flags_pkg::SZ_LONG: sizeMask = 32'hffffffff;
			default:            sizeMask = 32'h000000ff;
		endcase
	endfunction : sizeMask

	// Alignment for operands and fetches
	addr_align alignUnit (
		.rawAddr     (rawAddr),
		.wideAccess  (wideAccess),
		.fetch       (fetch),
		.alignedAddr (memAddr),     // [RULE14] [RULE15]
		.oddSeen     (oddAddr)
	);

	// Packed decimal correction of a byte
	decimal_adjust bcdUnit (
		.value    (operandA[7:0]),
		.subtract (opCode == flags_pkg::OP_DEC_SUB),
		.carryIn  (flagRegister[flags_pkg::BIT_CARRY]),
		.halfIn   (flagRegister[flags_pkg::BIT_HALF]),
		.adjusted (bcdOut),
		.carryOut (bcdCarry)
	);

	// Datapath and flag computation
	always_comb begin
		mask = sizeMask(opSize); // [RULE10]
		next_flags = flagRegister; // [RULE17]
		next_result = result;
		writeResult = 1'b1;
		sum = 33'h0;
		carry = 1'b0;
		ovf = 1'b0;
		half = 1'b0;
		msb = 1'b0;
		bitVal = operandA[bitSel] ^ bitInvert; // [RULE11]
		cIn = ((opCode == flags_pkg::OP_ADDX) || (opCode == flags_pkg::OP_SUBX))
			? flagRegister[flags_pkg::BIT_CARRY] : 1'b0;
		unique case (opCode)
			flags_pkg::OP_ADD, flags_pkg::OP_ADDX: begin
				sum = {1'b0, operandA & mask} + {1'b0, operandB & mask} + {32'h0, cIn};
				carry = sum[topBit(opSize) + 1]; // [RULE6]
				// Carry into the low bit of the top digit of the operand
				half = sum[topBit(opSize) - 3] ^ operandA[topBit(opSize) - 3]
					^ operandB[topBit(opSize) - 3];
				ovf = (operandA[topBit(opSize)] == operandB[topBit(opSize)])
					&& (sum[topBit(opSize)] != operandA[topBit(opSize)]); // [RULE5]
				next_result = sum[31:0] & mask;
			end
			flags_pkg::OP_SUB, flags_pkg::OP_SUBX: begin
				sum = {1'b0, operandA & mask} - {1'b0, operandB & mask} - {32'h0, cIn};
				carry = sum[topBit(opSize) + 1]; // [RULE7]
				// Borrow into the low bit of the top digit of the operand
				half = sum[topBit(opSize) - 3] ^ operandA[topBit(opSize) - 3]
					^ operandB[topBit(opSize) - 3];
				ovf = (operandA[topBit(opSize)] != operandB[topBit(opSize)])
					&& (sum[topBit(opSize)] != operandA[topBit(opSize)]); // [RULE5]
				next_result = sum[31:0] & mask;
			end
			flags_pkg::OP_LOGIC: begin
				next_result = operandA & mask;
				carry = flagRegister[flags_pkg::BIT_CARRY];
			end
			flags_pkg::OP_SHL: begin
				carry = operandA[topBit(opSize)]; // [RULE8]
				next_result = ((operandA << 1) | {31'h0, rotate & carry}) & mask;
			end
			flags_pkg::OP_SHR: begin
				carry = operandA[0]; // [RULE8]
				next_result = (operandA & mask) >> 1;
				if (rotate) begin
					next_result[topBit(opSize)] = carry;
				end
			end
			flags_pkg::OP_DEC_ADD, flags_pkg::OP_DEC_SUB: begin
				next_result = {24'h0, bcdOut}; // [RULE12]
				carry = bcdCarry;
			end
			default: begin
				next_result = result;
			end
		endcase
		msb = next_result[topBit(opSize)];
		if (opValid) begin
			unique case (opCode)
				flags_pkg::OP_ADD, flags_pkg::OP_SUB, flags_pkg::OP_ADDX,
				flags_pkg::OP_SUBX, flags_pkg::OP_SHL, flags_pkg::OP_SHR,
				flags_pkg::OP_LOGIC, flags_pkg::OP_DEC_ADD,
				flags_pkg::OP_DEC_SUB: begin
					next_flags[flags_pkg::BIT_NEG] = msb; // [RULE3]
					next_flags[flags_pkg::BIT_ZERO] = (next_result == 32'h0); // [RULE4]
					next_flags[flags_pkg::BIT_OVF] = ovf; // [RULE5]
					next_flags[flags_pkg::BIT_CARRY] = carry; // [RULE6] [RULE7] [RULE8]
					if (opCode inside {flags_pkg::OP_ADD, flags_pkg::OP_SUB,
						flags_pkg::OP_ADDX, flags_pkg::OP_SUBX}) begin
						next_flags[flags_pkg::BIT_HALF] = half;
					end
				end
				flags_pkg::OP_BIT_LD: begin
					next_flags[flags_pkg::BIT_CARRY] = bitVal; // [RULE9]
					writeResult = 1'b0;
				end
				flags_pkg::OP_BIT_AND: begin
					next_flags[flags_pkg::BIT_CARRY] = flagRegister[0] & bitVal; // [RULE9]
					writeResult = 1'b0;
				end
				flags_pkg::OP_BIT_OR: begin
					next_flags[flags_pkg::BIT_CARRY] = flagRegister[0] | bitVal; // [RULE9]
					writeResult = 1'b0;
				end
				flags_pkg::OP_BIT_XOR: begin
					next_flags[flags_pkg::BIT_CARRY] = flagRegister[0] ^ bitVal; // [RULE9]
					writeResult = 1'b0;
				end
				flags_pkg::OP_BIT_ST: begin
					next_result = {24'h0, operandA[7:0]};
					next_result[bitSel] = flagRegister[0] ^ bitInvert; // [RULE9] [RULE11]
				end
				flags_pkg::OP_FLAGS: begin
					writeResult = 1'b0;
					unique case (flagOp) // [RULE2]
						flags_pkg::FX_LOAD: next_flags = flagImm;
						flags_pkg::FX_AND:  next_flags = flagRegister & flagImm;
						flags_pkg::FX_OR:   next_flags = flagRegister | flagImm;
						flags_pkg::FX_XOR:  next_flags = flagRegister ^ flagImm;
					endcase
				end
				default: begin
					writeResult = 1'b0;
				end
			endcase
		end else begin
			writeResult = 1'b0;
		end
	end

	// Flag register, reset sets the mask bit and clears all other bits
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			flagRegister <= flags_pkg::FLAG_RESET; // [RULE1]
		end else begin
			flagRegister <= next_flags; // [RULE17]
		end
	end

	// Result register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			result <= 32'h0;
		end else if (writeResult) begin
			result <= next_result;
		end
	end

	// Checks
	a_zero_flag: assert property (@(posedge ref_clk) disable iff (reset) // [RULE4]
		opValid && opCode == flags_pkg::OP_ADD && opSize == flags_pkg::SZ_BYTE
		&& ((operandA[7:0] + operandB[7:0]) & 9'h0ff) == 9'h0
		|=> flagRegister[2]) else $error("zero flag not set");
	a_carry_add: assert property (@(posedge ref_clk) disable iff (reset) // [RULE6]
		opValid && opCode == flags_pkg::OP_ADD && opSize == flags_pkg::SZ_BYTE
		|=> flagRegister[0] == $past(({1'b0, operandA[7:0]} + {1'b0, operandB[7:0]}) >> 8))
		else $error("carry wrong after add");
	a_borrow_sub: assert property (@(posedge ref_clk) disable iff (reset) // [RULE7]
		opValid && opCode == flags_pkg::OP_SUB && opSize == flags_pkg::SZ_BYTE
		|=> flagRegister[0] == $past(operandA[7:0] < operandB[7:0]))
		else $error("borrow wrong after sub");
	a_shift_out: assert property (@(posedge ref_clk) disable iff (reset) // [RULE8]
		opValid && opCode == flags_pkg::OP_SHR |=> flagRegister[0] == $past(operandA[0]))
		else $error("shift carry wrong");
	a_sign_flag: assert property (@(posedge ref_clk) disable iff (reset) // [RULE3]
		opValid && opCode == flags_pkg::OP_LOGIC && opSize == flags_pkg::SZ_WORD
		|=> flagRegister[3] == $past(operandA[15])) else $error("sign flag wrong");
	a_bit_load: assert property (@(posedge ref_clk) disable iff (reset) // [RULE9]
		opValid && opCode == flags_pkg::OP_BIT_LD
		|=> flagRegister[0] == $past(operandA[bitSel] ^ bitInvert)) else $error("bit load");
	a_flags_hold: assert property (@(posedge ref_clk) disable iff (reset) // [RULE17]
		!opValid |=> $stable(flagRegister)) else $error("flags changed while idle");
	a_user_bit: assert property (@(posedge ref_clk) disable iff (reset) // [RULE2]
		opValid && opCode != flags_pkg::OP_FLAGS |=> $stable(flagRegister[4]))
		else $error("user bit touched");
	a_even_addr: assert property (@(posedge ref_clk) disable iff (reset) // [RULE14]
		(wideAccess || fetch) |-> memAddr[0] == 1'b0 && memAddr[15:1] == rawAddr[15:1])
		else $error("address not aligned");
	c_add_carry: cover property (@(posedge ref_clk) opValid && opCode == flags_pkg::OP_ADD
		##1 flagRegister[0]);
	c_odd_fetch: cover property (@(posedge ref_clk) fetch && rawAddr[0]);
	c_flag_load: cover property (@(posedge ref_clk) opValid && opCode == flags_pkg::OP_FLAGS);
	c_bit_store: cover property (@(posedge ref_clk) opValid && opCode == flags_pkg::OP_BIT_ST);
	c_dec_add: cover property (@(posedge ref_clk) opValid && opCode == flags_pkg::OP_DEC_ADD);

	// Reference sums taken straight from the operands
	logic [8:0]  byteSum;
	logic [32:0] longSum;
	assign byteSum = {1'b0, operandA[7:0]} + {1'b0, operandB[7:0]};
	assign longSum = {1'b0, operandA} + {1'b0, operandB};

	// Flags after arithmetic and shifts
	a_zero_clear: assert property (@(posedge ref_clk) disable iff (reset) // [RULE4]
		opValid && opCode == flags_pkg::OP_ADD && opSize == flags_pkg::SZ_BYTE
		&& byteSum[7:0] != 8'h00 |=> !flagRegister[flags_pkg::BIT_ZERO])
		else $error("zero flag not cleared");
	a_sign_add: assert property (@(posedge ref_clk) disable iff (reset) // [RULE3]
		opValid && opCode == flags_pkg::OP_ADD && opSize == flags_pkg::SZ_BYTE
		|=> flagRegister[flags_pkg::BIT_NEG] == $past(byteSum[7]))
		else $error("sign flag wrong after add");
	a_ovf_add: assert property (@(posedge ref_clk) disable iff (reset) // [RULE5]
		opValid && opCode == flags_pkg::OP_ADD && opSize == flags_pkg::SZ_BYTE
		|=> flagRegister[flags_pkg::BIT_OVF]
		== $past(operandA[7] == operandB[7] && byteSum[7] != operandA[7]))
		else $error("overflow wrong after add");
	a_ovf_clear: assert property (@(posedge ref_clk) disable iff (reset) // [RULE5]
		opValid && opCode inside {flags_pkg::OP_LOGIC, flags_pkg::OP_SHL, flags_pkg::OP_SHR}
		|=> !flagRegister[flags_pkg::BIT_OVF]) else $error("overflow set without arithmetic");
	a_shift_left: assert property (@(posedge ref_clk) disable iff (reset) // [RULE8]
		opValid && opCode == flags_pkg::OP_SHL && opSize == flags_pkg::SZ_BYTE
		|=> flagRegister[flags_pkg::BIT_CARRY] == $past(operandA[7]))
		else $error("left shift carry wrong");
	a_long_carry: assert property (@(posedge ref_clk) disable iff (reset) // [RULE10]
		opValid && opCode == flags_pkg::OP_ADD && opSize == flags_pkg::SZ_LONG
		|=> flagRegister[flags_pkg::BIT_CARRY] == $past(longSum[32]))
		else $error("longword carry wrong");

	// Bit instructions
	a_bit_store: assert property (@(posedge ref_clk) disable iff (reset) // [RULE9]
		opValid && opCode == flags_pkg::OP_BIT_ST
		|=> result[$past(bitSel)] == $past(flagRegister[flags_pkg::BIT_CARRY] ^ bitInvert))
		else $error("stored bit wrong");
	a_bit_keep: assert property (@(posedge ref_clk) disable iff (reset) // [RULE11]
		opValid && opCode == flags_pkg::OP_BIT_ST |=> result[31:8] == 24'h0
		&& ((result[7:0] ^ $past(operandA[7:0])) & ~(8'h01 << $past(bitSel))) == 8'h00)
		else $error("bit store touched other bits");
	a_bit_result: assert property (@(posedge ref_clk) disable iff (reset) // [RULE9]
		opValid && opCode inside {flags_pkg::OP_BIT_LD, flags_pkg::OP_BIT_AND,
		flags_pkg::OP_BIT_OR, flags_pkg::OP_BIT_XOR} |=> $stable(result))
		else $error("bit test changed result");

	// Flag instructions, idle cycles and reset
	a_flags_load: assert property (@(posedge ref_clk) disable iff (reset) // [RULE2]
		opValid && opCode == flags_pkg::OP_FLAGS && flagOp == flags_pkg::FX_LOAD
		|=> flagRegister == $past(flagImm)) else $error("flag load wrong");
	a_result_hold: assert property (@(posedge ref_clk) disable iff (reset) // [RULE17]
		!opValid |=> $stable(result)) else $error("result changed while idle");
	a_reset_value: assert property (@(posedge ref_clk) // [RULE1]
		reset |=> flagRegister == flags_pkg::FLAG_RESET && result == 32'h0)
		else $error("reset value wrong");

	// Address alignment
	a_fetch_even: assert property (@(posedge ref_clk) disable iff (reset) // [RULE15]
		fetch |-> memAddr == {rawAddr[15:1], 1'b0} && oddAddr == rawAddr[0])
		else $error("fetch address not aligned");
	a_narrow_addr: assert property (@(posedge ref_clk) disable iff (reset) // [RULE14]
		!wideAccess && !fetch |-> memAddr == rawAddr && !oddAddr)
		else $error("byte address altered");
endmodule : cpu_flags

/* File: design/decimal_adjust.sv */
`timescale 1ns/1ns
// Corrects a byte holding two packed decimal digits
module decimal_adjust (
	input  wire logic [7:0] value,
	input  wire logic       subtract,
	input  wire logic       carryIn,
	input  wire logic       halfIn,
	output logic      [7:0] adjusted,
	output logic            carryOut
);
	logic [7:0] corr;
	// Correction per digit, low digit then high digit
	always_comb begin
		corr = 8'h00;
		carryOut = carryIn;
		if (!subtract) begin
			if (halfIn || value[3:0] > 4'h9) begin
				corr[3:0] = 4'h6;
			end
			if (carryIn || value > 8'h99) begin
				corr[7:4] = 4'h6;
				carryOut = 1'b1;
			end
			adjusted = value + corr;
		end else begin
			if (halfIn) begin
				corr[3:0] = 4'h6;
			end
			if (carryIn) begin
				corr[7:4] = 4'h6;
			end
			adjusted = value - corr;
		end
	end
endmodule : decimal_adjust

/* File: design/flags_pkg.sv */
package flags_pkg;
	// Flag register layout
	localparam int FLAG_WIDTH   = 8;
	localparam int BIT_IMASK    = 7;
	localparam int BIT_UBIT6    = 6;
	localparam int BIT_HALF     = 5;
	localparam int BIT_USER     = 4;
	localparam int BIT_NEG      = 3;
	localparam int BIT_ZERO     = 2;
	localparam int BIT_OVF      = 1;
	localparam int BIT_CARRY    = 0;
	localparam logic [7:0] FLAG_RESET  = 8'h80;
	// Update mask for the user bit kept by this block
	localparam logic [7:0] USER_MASK   = 8'h10;

	// Operand sizes
	typedef enum logic [2:0] {
		SZ_BIT  = 3'b000,
		SZ_BCD  = 3'b001,
		SZ_BYTE = 3'b010,
		SZ_WORD = 3'b011,
		SZ_LONG = 3'b100
	} size_t;

	// Operations
	typedef enum logic [3:0] {
		OP_NONE    = 4'h0,
		OP_ADD     = 4'h1,
		OP_SUB     = 4'h2,
		OP_ADDX    = 4'h3,
		OP_SUBX    = 4'h4,
		OP_LOGIC   = 4'h5,
		OP_SHL     = 4'h6,
		OP_SHR     = 4'h7,
		OP_DEC_ADD = 4'h8,
		OP_DEC_SUB = 4'h9,
		OP_BIT_LD  = 4'ha,
		OP_BIT_ST  = 4'hb,
		OP_BIT_AND = 4'hc,
		OP_BIT_OR  = 4'hd,
		OP_BIT_XOR = 4'he,
		OP_FLAGS   = 4'hf
	} op_t;

	// Flag-register instruction variants
	typedef enum logic [1:0] {
		FX_LOAD = 2'b00,
		FX_AND  = 2'b01,
		FX_OR   = 2'b10,
		FX_XOR  = 2'b11
	} flagop_t;
endpackage : flags_pkg

/* File: sim/cpu_flags_tb_top.sv */
`timescale 1ns/1ns
module cpu_flags_tb_top;
	logic                ref_clk, reset, opValid, rotate, bitInvert, wideAccess, fetch;
	flags_pkg::op_t      opCode;
	flags_pkg::size_t    opSize;
	flags_pkg::flagop_t  flagOp, fop;
	logic [31:0]         operandA, operandB, result;
	logic [2:0]          bitSel, sel;
	logic [7:0]          flagImm, flagRegister, imm, lowFlags;
	logic [15:0]         rawAddr, memAddr;
	logic                oddAddr, inv, rot;
	int                  errors, checks;
	assign lowFlags = {3'h0, flagRegister[4:0]};

	cpu_flags cpu_flags_i (.ref_clk(ref_clk), .reset(reset), .opValid(opValid),
		.opCode(opCode), .opSize(opSize), .operandA(operandA), .operandB(operandB),
		.rotate(rotate), .bitSel(bitSel), .bitInvert(bitInvert), .flagOp(flagOp),
		.flagImm(flagImm), .rawAddr(rawAddr), .wideAccess(wideAccess), .fetch(fetch),
		.result(result), .flagRegister(flagRegister), .memAddr(memAddr), .oddAddr(oddAddr));

	// Clock generation
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Compare tasks
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk8
	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk32
	task automatic chkAd(input string n, input logic [16:0] e, input logic [16:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chkAd

	// One instruction, operands launched at an edge and taken at the next
	task automatic ex(input flags_pkg::op_t o, input flags_pkg::size_t s,
			input logic [31:0] a, input logic [31:0] b);
		@(posedge ref_clk);
		opValid   <= 1'b1;
		opCode    <= o;
		opSize    <= s;
		operandA  <= a;
		operandB  <= b;
		bitSel    <= sel;
		bitInvert <= inv;
		flagOp    <= fop;
		flagImm   <= imm;
		rotate    <= rot;
		@(posedge ref_clk);
		opValid   <= 1'b0;
		#1;
	endtask : ex

	// Arithmetic then result and low flags compare
	task automatic ar(input flags_pkg::op_t o, input flags_pkg::size_t s,
			input logic [31:0] a, input logic [31:0] b, input logic [31:0] r, input logic [7:0] f);
		ex(o, s, a, b);
		chk32("result", r, result);
		chk8("low flags", f, lowFlags);
	endtask : ar

	// Bit instruction, then carry compare
	task automatic bt(input flags_pkg::op_t o, input logic [2:0] s, input logic i,
			input logic [7:0] a, input logic c);
		sel = s;
		inv = i;
		ex(o, flags_pkg::SZ_BIT, {24'h0, a}, 32'h0);
		chk8("bit accumulator", {7'h0, c}, {7'h0, flagRegister[0]});
		chk8("untouched flags", 8'h10, {3'h0, flagRegister[4:1], 1'b0});
	endtask : bt

	task automatic flagOpTest(input flags_pkg::flagop_t f, input logic [7:0] i, input logic [7:0] e);
		fop = f;
		imm = i;
		ex(flags_pkg::OP_FLAGS, flags_pkg::SZ_BYTE, 32'h0, 32'h0);
		chk8("flag register", e, flagRegister);
	endtask : flagOpTest

	task automatic test_flags;
		chk8("flags after reset", 8'h80, flagRegister);
		chk32("result after reset", 32'h0, result);
		flagOpTest(flags_pkg::FX_LOAD, 8'h10, 8'h10);
		flagOpTest(flags_pkg::FX_OR, 8'h81, 8'h91);
		flagOpTest(flags_pkg::FX_AND, 8'h1f, 8'h11);
		flagOpTest(flags_pkg::FX_XOR, 8'h01, 8'h10);
		$display("test_flags done");
	endtask : test_flags

	task automatic test_arith;
		ar(flags_pkg::OP_ADD, flags_pkg::SZ_BYTE, 32'hff, 32'h1, 32'h0, 8'h15);
		ar(flags_pkg::OP_ADD, flags_pkg::SZ_BYTE, 32'h7f, 32'h1, 32'h80, 8'h1a);
		ar(flags_pkg::OP_ADD, flags_pkg::SZ_WORD, 32'hffff, 32'h1, 32'h0, 8'h15);
		ar(flags_pkg::OP_ADD, flags_pkg::SZ_LONG, 32'h7fffffff, 32'h1, 32'h80000000, 8'h1a);
		ar(flags_pkg::OP_SUB, flags_pkg::SZ_BYTE, 32'h0, 32'h1, 32'hff, 8'h19);
		ar(flags_pkg::OP_SUB, flags_pkg::SZ_BYTE, 32'h80, 32'h1, 32'h7f, 8'h12);
		ar(flags_pkg::OP_SHL, flags_pkg::SZ_BYTE, 32'h81, 32'h0, 32'h2, 8'h11);
		ar(flags_pkg::OP_SHR, flags_pkg::SZ_BYTE, 32'h1, 32'h0, 32'h0, 8'h15);
		rot = 1'b1;
		ar(flags_pkg::OP_SHL, flags_pkg::SZ_BYTE, 32'h81, 32'h0, 32'h3, 8'h11);
		ar(flags_pkg::OP_SHR, flags_pkg::SZ_BYTE, 32'h1, 32'h0, 32'h80, 8'h19);
		rot = 1'b0;
		ar(flags_pkg::OP_LOGIC, flags_pkg::SZ_WORD, 32'h8000, 32'h0, 32'h8000, 8'h19);
		ar(flags_pkg::OP_ADDX, flags_pkg::SZ_BYTE, 32'hff, 32'h0, 32'h0, 8'h15);
		ar(flags_pkg::OP_SUBX, flags_pkg::SZ_BYTE, 32'h10, 32'h1, 32'he, 8'h10);
		$display("test_arith done");
	endtask : test_arith

	task automatic test_bits;
		bt(flags_pkg::OP_BIT_LD, 3'h5, 1'b0, 8'hdf, 1'b0);
		chk32("result kept", 32'he, result);
		bt(flags_pkg::OP_BIT_LD, 3'h7, 1'b0, 8'h80, 1'b1);
		bt(flags_pkg::OP_BIT_XOR, 3'h3, 1'b0, 8'h08, 1'b0);
		bt(flags_pkg::OP_BIT_LD, 3'h0, 1'b1, 8'h00, 1'b1);
		bt(flags_pkg::OP_BIT_AND, 3'h1, 1'b0, 8'h00, 1'b0);
		bt(flags_pkg::OP_BIT_OR, 3'h1, 1'b0, 8'h02, 1'b1);
		bt(flags_pkg::OP_BIT_ST, 3'h2, 1'b0, 8'ha0, 1'b1);
		chk8("stored bit", 8'ha4, result[7:0]);
		$display("test_bits done");
	endtask : test_bits

	task automatic test_decimal;
		ex(flags_pkg::OP_ADD, flags_pkg::SZ_BYTE, 32'h09, 32'h01);
		ex(flags_pkg::OP_DEC_ADD, flags_pkg::SZ_BCD, 32'h0a, 32'h0);
		chk8("adjusted sum", 8'h10, result[7:0]);
		ex(flags_pkg::OP_ADD, flags_pkg::SZ_BYTE, 32'h99, 32'h01);
		ar(flags_pkg::OP_DEC_ADD, flags_pkg::SZ_BCD, 32'h9a, 32'h0, 32'h0, 8'h15);
		ex(flags_pkg::OP_SUB, flags_pkg::SZ_BYTE, 32'h10, 32'h01);
		ex(flags_pkg::OP_DEC_SUB, flags_pkg::SZ_BCD, 32'h0f, 32'h0);
		chk8("adjusted difference", 8'h09, result[7:0]);
		$display("test_decimal done");
	endtask : test_decimal

	task automatic test_idle;
		logic [7:0]  f;
		logic [31:0] r;
		f = flagRegister;
		r = result;
		ex(flags_pkg::OP_NONE, flags_pkg::SZ_BYTE, 32'h0, 32'h0);
		@(posedge ref_clk);
		opCode   <= flags_pkg::OP_ADD;
		operandA <= 32'hff;
		operandB <= 32'h1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk8("idle flags", f, flagRegister);
		chk32("idle result", r, result);
		$display("test_idle done");
	endtask : test_idle

	task automatic test_addr;
		logic [17:0] t [5];
		// Last entry is an even word access to the stack, as software keeps it
		t = '{{16'h1235, 2'b10}, {16'h1235, 2'b01}, {16'h1235, 2'b00}, {16'h1234, 2'b11},
			{16'h1234, 2'b10}};
		foreach (t[k]) begin
			@(posedge ref_clk);
			rawAddr    <= t[k][17:2];
			wideAccess <= t[k][1];
			fetch      <= t[k][0];
			#1;
			chkAd("address", (|t[k][1:0]) ? {16'h1234, t[k][2]} : {16'h1235, 1'b0},
				{memAddr, oddAddr});
		end
		$display("test_addr done");
	endtask : test_addr

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test

	// Watchdog
	initial begin
		repeat (3000) @(posedge ref_clk);
		errors++;
		end_of_test();
	end

	// Main sequence
	initial begin
		{reset, opValid, rotate, bitInvert, wideAccess, fetch, rawAddr} = '0;
		{operandA, operandB, bitSel, flagImm, sel, inv, rot, imm} = '0;
		opCode = flags_pkg::OP_NONE;
		opSize = flags_pkg::SZ_BIT;
		flagOp = flags_pkg::FX_LOAD;
		fop = flags_pkg::FX_LOAD;
		errors = 0;
		checks = 0;
		reset = 1'b1;
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1;
		test_flags();
		test_arith();
		test_bits();
		test_decimal();
		test_idle();
		test_addr();
		end_of_test();
	end
endmodule : cpu_flags_tb_top
